// ==== core/hdlc_crc_and_async_timeout.sv ====
// Channel framing options: flags, CRC preset/width, async time-out, APB.
// Notes on behaviour
// - Queued next frame reuses closing flag.
// - Shared flag off sends two flags.
// - Receiver accepts shared flags and zeros.
// - Time-out issues receive frame end command.
// - Time-out forces FIFO forward below threshold.
// - Time-out closes descriptor with block end.
// - Time-out processing only when enabled.
// - Time-out after silence of configured period.
// - Period is (length+1) times four characters.
// - Character time counts start, parity, stop.
// - Preset zero selects all-ones CRC start.
// - Preset one selects all-zeros CRC start.
// - Width select picks 16 or 32 CRC.
// - Minimum frame length follows CRC bytes.
// - Config two registers reset zero, RW.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "hdlc_crc_consts.svh"
module hdlc_crc_and_async_timeout
	import hdlc_crc_pkg::*;
#(
	parameter int CHAN_SEL = 0,
	parameter int LEN_W = 12
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// APB slave.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	// Transmit framing.
	input wire logic tx_frame_done_in,
	input wire logic tx_next_queued_in,
	input wire logic tx_bit_valid_in,
	input wire logic tx_bit_in,
	output logic tx_flag_out,
	output logic tx_start_next_out,
	output logic [31:0] tx_crc_out,
	// HDLC receive bit stream.
	input wire logic rx_bit_valid_in,
	input wire logic rx_bit_in,
	output logic rx_flag_out,
	output logic rx_frame_ok_out,
	output logic rx_frame_bad_out,
	output logic [31:0] rx_crc_out,
	// Asynchronous receive time-out.
	input wire logic bit_tick_in,
	input wire logic [3:0] char_frame_bits_in,
	input wire logic rx_char_done_in,
	output logic receive_frame_end_command_out,
	output logic fifo_force_forward_out,
	output logic dma_block_end_out
);

	// One serial CRC step, LSB first, reflected polynomial.
	function automatic logic [31:0] crc_step(input logic [31:0] c,
			input logic b, input logic wide);
		logic fb;
		logic [31:0] poly;
		fb = c[0] ^ b;
		poly = wide ? `POLY32_REFL : `POLY16_REFL;
		crc_step = (c >> 1) ^ (fb ? poly : `PRESET_ZEROS);
	endfunction

	logic [31:0] cfg_q [4];
	logic [2:0] stat_q, stat_d, mask_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, irq_q;
	chan_cfg_t cfg;

	// Field decode of the register that steers this channel.
	assign cfg.crc_wide = cfg_q[CHAN_SEL][`BIT_CRC_WIDTH];
	assign cfg.crc_preset = cfg_q[CHAN_SEL][`BIT_CRC_PRESET];
	assign cfg.shared_flag = cfg_q[CHAN_SEL][`BIT_SHARED_FLAG];
	assign cfg.to_enable = cfg_q[CHAN_SEL][`BIT_TO_ENABLE];
	assign cfg.to_len = cfg_q[CHAN_SEL][`TO_LEN_MSB:`TO_LEN_LSB];

	// Address decode; the access phase ends one cycle after it starts.
	wire access = psel_in & penable_in;
	wire done = access & pready_q;
	wire hit0 = paddr_in == `CFG2_CH0_OFS;
	wire hit1 = paddr_in == `CFG2_CH1_OFS;
	wire hit2 = paddr_in == `CFG2_CH2_OFS;
	wire hit3 = paddr_in == `CFG2_CH3_OFS;
	wire hit_st = paddr_in == `STATUS_OFS;
	wire hit_mk = paddr_in == `MASK_OFS;
	wire mapped = hit0 | hit1 | hit2 | hit3 | hit_st | hit_mk;
	wire [3:0] hit_cfg = {hit3, hit2, hit1, hit0};
	wire [31:0] rd_mux = hit0 ? cfg_q[0] : hit1 ? cfg_q[1] :
		hit2 ? cfg_q[2] : hit3 ? cfg_q[3] :
		hit_st ? {29'h0, stat_q} : hit_mk ? {29'h0, mask_q} :
		32'h0000_0000;
	wire st_read = done & ~pwrite_in & hit_st;

	// Bus handshake and read data, all registered.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= access & ~pready_q;
			pslverr_q <= access & ~pready_q & ~mapped;
			prdata_q <= (access & ~pready_q) ? rd_mux : 32'h0000_0000;
		end
	end

	// Config registers: written only at the completing edge.
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < 4; i++) begin
			if (sys_rst_in)
				cfg_q[i] <= `CFG2_RESET;
			else if (done & pwrite_in & hit_cfg[i])
				cfg_q[i] <= pwdata_in;
		end
	end

	// Mask register.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			mask_q <= `STAT_RESET;
		else if (done & pwrite_in & hit_mk)
			mask_q <= pwdata_in[2:0];
	end

	// Transmit flag sequencing after each frame.
	tx_state_t tx_q, tx_d;
	logic tx_flag_q, tx_next_q;
	always_comb begin
		tx_d = tx_q;
		case (tx_q)
			TX_DATA: if (tx_frame_done_in) tx_d = TX_CLOSE;
			TX_CLOSE: if (tx_next_queued_in & ~cfg.shared_flag)
				tx_d = TX_OPEN;
				else tx_d = TX_DATA;
			TX_OPEN: tx_d = TX_DATA;
			default: tx_d = TX_DATA;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tx_q <= TX_DATA;
			tx_flag_q <= 1'b0;
			tx_next_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			tx_flag_q <= (tx_q == TX_CLOSE) | (tx_q == TX_OPEN);
			// The closing flag opens the next frame when sharing.
			tx_next_q <= (tx_q == TX_CLOSE & tx_next_queued_in &
				cfg.shared_flag) | (tx_q == TX_OPEN);
		end
	end

	// CRC preset depends on width and preset select.
	wire [31:0] preset = cfg.crc_preset ? `PRESET_ZEROS :
		cfg.crc_wide ? `PRESET32_ONES : `PRESET16_ONES;

	// Transmit CRC restarts at each frame boundary.
	logic [31:0] tx_crc_q;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in)
			tx_crc_q <= `PRESET_ZEROS;
		else if (tx_flag_q)
			tx_crc_q <= preset;
		else if (tx_bit_valid_in)
			tx_crc_q <= crc_step(tx_crc_q, tx_bit_in, cfg.crc_wide);
	end

	// Receive flag hunt over a sliding window: a zero shared by two
	// flags, or one flag between frames, is seen without a gap.
	logic [7:0] rx_sh_q;
	logic [LEN_W-1:0] rx_bits_q;
	logic [31:0] rx_crc_q;
	logic rx_flag_q, rx_ok_q, rx_bad_q;
	wire [7:0] rx_sh_d = {rx_bit_in, rx_sh_q[7:1]};
	wire rx_flag_now = rx_bit_valid_in & (rx_sh_d == `FLAG_PATTERN);
	wire [3:0] crc_bytes = cfg.crc_wide ? `CRC32_BYTES : `CRC16_BYTES;
	wire [LEN_W-1:0] min_bits = LEN_W'((crc_bytes + `HEADER_BYTES) * 8);
	// Flag bits minus one were already counted as frame bits.
	wire [LEN_W-1:0] frame_bits = rx_bits_q - LEN_W'(7);
	wire had_frame = rx_bits_q > LEN_W'(7);
	wire long_enough = frame_bits >= min_bits;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rx_sh_q <= 8'h00;
			rx_bits_q <= '0;
			rx_crc_q <= `PRESET_ZEROS;
			rx_flag_q <= 1'b0;
			rx_ok_q <= 1'b0;
			rx_bad_q <= 1'b0;
		end else begin
			rx_flag_q <= rx_flag_now;
			rx_ok_q <= rx_flag_now & had_frame & long_enough;
			rx_bad_q <= rx_flag_now & had_frame & ~long_enough;
			if (rx_bit_valid_in)
				rx_sh_q <= rx_sh_d;
			if (rx_flag_now) begin
				rx_bits_q <= '0;
				rx_crc_q <= preset;
			end else if (rx_bit_valid_in) begin
				if (rx_bits_q != '1)
					rx_bits_q <= rx_bits_q + LEN_W'(1);
				rx_crc_q <= crc_step(rx_crc_q, rx_bit_in, cfg.crc_wide);
			end
		end
	end

	// Asynchronous idle timer in whole character frame times.
	logic [3:0] bit_cnt_q;
	logic [9:0] char_cnt_q;
	logic armed_q, to_q;
	wire [9:0] char_limit = 10'((cfg.to_len + 10'd1) <<
		`CHARS_PER_UNIT);
	wire char_end = bit_tick_in &
		(bit_cnt_q == char_frame_bits_in - 4'd1);
	wire expire = char_end & (char_cnt_q == char_limit - 10'd1) &
		armed_q & cfg.to_enable;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in | rx_char_done_in | ~cfg.to_enable) begin
			bit_cnt_q <= 4'h0;
			char_cnt_q <= 10'h000;
		end else if (bit_tick_in) begin
			bit_cnt_q <= char_end ? 4'h0 : bit_cnt_q + 4'd1;
			if (char_end & armed_q)
				char_cnt_q <= char_cnt_q + 10'd1;
		end
	end
	// Arming waits for a character so a silent line fires only once.
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			armed_q <= 1'b0;
			to_q <= 1'b0;
		end else begin
			to_q <= expire;
			if (rx_char_done_in)
				armed_q <= 1'b1;
			else if (expire)
				armed_q <= 1'b0;
		end
	end

	// Sticky status: a hardware set wins over the read clear.
	wire [2:0] stat_set = {rx_bad_q, rx_ok_q, to_q};
	assign stat_d = (st_read ? 3'h0 : stat_q) | stat_set;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			stat_q <= `STAT_RESET;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q <= |(stat_d & mask_q);
		end
	end

	// Output drive.
	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign irq_out = irq_q;
	assign tx_flag_out = tx_flag_q;
	assign tx_start_next_out = tx_next_q;
	assign tx_crc_out = tx_crc_q;
	assign rx_flag_out = rx_flag_q;
	assign rx_frame_ok_out = rx_ok_q;
	assign rx_frame_bad_out = rx_bad_q;
	assign rx_crc_out = rx_crc_q;
	// One pulse serves all three consumers of the time-out marker.
	assign receive_frame_end_command_out = to_q;
	assign fifo_force_forward_out = to_q;
	assign dma_block_end_out = to_q;

	a_shared_one_flag: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(tx_q == TX_CLOSE && tx_next_queued_in && cfg.shared_flag)
		|=> tx_flag_q && tx_next_q ##1 !tx_flag_q)
		else $error("shared flag not reused");
	a_two_flags: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(tx_q == TX_CLOSE && tx_next_queued_in && !cfg.shared_flag)
		|=> tx_flag_q && !tx_next_q ##1 tx_flag_q && tx_next_q)
		else $error("separate flags not sent");
	a_rx_flag_seen: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		(rx_bit_valid_in && {rx_bit_in, rx_sh_q[7:1]} == 8'h7E)
		|=> rx_flag_q)
		else $error("flag missed");
	a_timeout_pulse: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		to_q |-> receive_frame_end_command_out &&
		fifo_force_forward_out && dma_block_end_out
		##1 !to_q && stat_q[`ST_TIMEOUT])
		else $error("time-out marker wrong");
	a_timeout_gated: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		!cfg.to_enable && !$past(cfg.to_enable) |-> !to_q)
		else $error("time-out while disabled");
	a_once_per_idle: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		to_q && !rx_char_done_in |=> !armed_q)
		else $error("timer still armed");
	a_count_limit: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		expire |-> char_cnt_q == 10'(((cfg.to_len + 1) * 4) - 1))
		else $error("wrong period");
	a_preset_value: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		$rose(tx_flag_q) |=> tx_crc_q == (cfg.crc_preset ? 32'h0 :
		cfg.crc_wide ? 32'hFFFF_FFFF : 32'h0000_FFFF))
		else $error("bad CRC preset");
	a_min_length: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		rx_ok_q |-> $past(frame_bits) >=
		(cfg.crc_wide ? 12'd48 : 12'd32))
		else $error("short frame passed");
	a_reg_reset: assert property (@(posedge clk_in)
		$past(sys_rst_in) |-> cfg_q[CHAN_SEL] == 32'h0)
		else $error("config not reset");
endmodule

// ==== core/hdlc_crc_consts.svh ====
// Register map, field positions and fixed values for the channel options.
`ifndef HDLC_CRC_CONSTS_SVH
`define HDLC_CRC_CONSTS_SVH
`define CFG2_CH0_OFS 12'h110
`define CFG2_CH1_OFS 12'h190
`define CFG2_CH2_OFS 12'h210
`define CFG2_CH3_OFS 12'h290
`define STATUS_OFS 12'h300
`define MASK_OFS 12'h304
`define CFG2_RESET 32'h0000_0000
`define STAT_RESET 3'h0
`define BIT_CRC_WIDTH 0
`define BIT_CRC_PRESET 2
`define BIT_SHARED_FLAG 7
`define BIT_TO_ENABLE 15
`define TO_LEN_LSB 8
`define TO_LEN_MSB 14
`define ST_TIMEOUT 0
`define ST_FRAME_OK 1
`define ST_FRAME_BAD 2
`define FLAG_PATTERN 8'h7E
`define POLY16_REFL 32'h0000_8408
`define POLY32_REFL 32'hEDB8_8320
`define PRESET16_ONES 32'h0000_FFFF
`define PRESET32_ONES 32'hFFFF_FFFF
`define PRESET_ZEROS 32'h0000_0000
`define CRC16_BYTES 4'h2
`define CRC32_BYTES 4'h4
`define HEADER_BYTES 4'h2
`define CHARS_PER_UNIT 2
`endif

// ==== core/hdlc_crc_pkg.sv ====
// Types shared by the channel option logic.
package hdlc_crc_pkg;
	typedef struct packed {
		logic to_enable;
		logic [6:0] to_len;
		logic shared_flag;
		logic crc_preset;
		logic crc_wide;
	} chan_cfg_t;
	typedef enum logic [1:0] {TX_DATA, TX_CLOSE, TX_OPEN} tx_state_t;
endpackage

// ==== testbench/hdlc_crc_and_async_timeout_bench.sv ====
// Self-checking bench for the channel framing options block.
`timescale 1ns/1ns
`include "hdlc_crc_consts.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	n_errors++; \
	$display("mismatch at %0t: got %0h expected %0h", $time, g, e); \
	end end
module hdlc_crc_and_async_timeout_bench;
	logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, tx_crc_out, rx_crc_out, rdat;
	logic pready_out, pslverr_out, irq_out, rerr;
	logic tx_frame_done_in, tx_next_queued_in, tx_flag_out;
	logic tx_bit_valid_in, tx_bit_in;
	logic tx_start_next_out, rx_bit_valid_in, rx_bit_in, rx_flag_out;
	logic rx_frame_ok_out, rx_frame_bad_out, bit_tick_in, rx_char_done_in;
	logic [3:0] char_frame_bits_in;
	logic receive_frame_end_command_out, fifo_force_forward_out;
	logic dma_block_end_out;
	logic [11:0] ofs [4] = '{`CFG2_CH0_OFS, `CFG2_CH1_OFS,
		`CFG2_CH2_OFS, `CFG2_CH3_OFS};
	int n_errors = 0, checks_done = 0, cyc = 0, f0, b0, r0;
	int n_txf = 0, n_nx = 0, n_ok = 0, n_bad = 0, n_rf = 0, n_to = 0;

	// The bench feeds transmit CRC bits itself; the station feeds receive.
	hdlc_crc_and_async_timeout dut (.clk_in, .sys_rst_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
		.pready_out, .pslverr_out, .irq_out, .tx_frame_done_in,
		.tx_next_queued_in, .tx_bit_valid_in, .tx_bit_in,
		.tx_flag_out, .tx_start_next_out, .tx_crc_out, .rx_bit_valid_in,
		.rx_bit_in, .rx_flag_out, .rx_frame_ok_out, .rx_frame_bad_out,
		.rx_crc_out, .bit_tick_in, .char_frame_bits_in, .rx_char_done_in,
		.receive_frame_end_command_out, .fifo_force_forward_out,
		.dma_block_end_out);
	serial_station stn (.clk_in, .rx_bit_valid_out(rx_bit_valid_in),
		.rx_bit_out(rx_bit_in), .bit_tick_out(bit_tick_in),
		.char_done_out(rx_char_done_in));

	// Free-running 20 MHz clock.
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	// Feeds one byte, LSB first, to the transmit CRC.
	task automatic tx_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			tx_bit_valid_in <= 1'b1;
			tx_bit_in <= b[i];
		end
		@(posedge clk_in);
		tx_bit_valid_in <= 1'b0;
	endtask

	// Pulse counters and the watchdog; a hang ends the run as a failure.
	always @(posedge clk_in) begin
		cyc++;
		n_txf += tx_flag_out;
		n_nx += tx_start_next_out;
		n_ok += rx_frame_ok_out;
		n_bad += rx_frame_bad_out;
		n_rf += rx_flag_out;
		n_to += receive_frame_end_command_out;
		if (receive_frame_end_command_out | fifo_force_forward_out |
				dma_block_end_out)
			`CHK({receive_frame_end_command_out, fifo_force_forward_out,
				dma_block_end_out}, 3'h7)
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	// Main sequence.
	initial begin
		sys_rst_in = 1'b1;
		{psel_in, penable_in, pwrite_in, tx_frame_done_in} = 4'h0;
		tx_next_queued_in = 1'b0;
		tx_bit_valid_in = 1'b0;
		tx_bit_in = 1'b0;
		paddr_in = 12'h000;
		pwdata_in = 32'h0000_0000;
		char_frame_bits_in = 4'hA;
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		// Channel registers reset to zero and keep what is written.
		foreach (ofs[i]) begin
			apb(1'b0, ofs[i], 32'h0);
			`CHK(rdat, 32'h0000_0000)
			apb(1'b1, ofs[i], 32'hA5C3_3C5A >> i);
			apb(1'b0, ofs[i], 32'h0);
			`CHK(rdat, 32'hA5C3_3C5A >> i)
		end
		apb(1'b0, 12'h004, 32'h0);
		`CHK({rerr, rdat}, {1'b1, 32'h0000_0000})
		// Every preset and width pairing, seen after a received flag.
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `CFG2_CH0_OFS, {29'h0, k[1], 1'b0, k[0]});
			stn.send_bits(`FLAG_PATTERN, 8);
			repeat (3) @(posedge clk_in);
			`CHK(rx_crc_out, k[1] ? 32'h0 : (k[0] ? 32'hFFFF_FFFF :
				32'h0000_FFFF))
			// From all ones, the digits 1 to 9 leave a well-known
			// register value for each width, so the polynomial counts.
			if (k < 2) begin
				for (int c = 8'h31; c <= 8'h39; c++)
					stn.send_bits(8'(c), 8);
				@(posedge clk_in);
				`CHK(rx_crc_out, k[0] ? 32'h340B_C6D9 :
					32'h0000_6F91)
			end
		end
		// One byte short of the minimum, then exactly the minimum; the
		// middle flag is shared and the last shares a zero.
		for (int w = 0; w < 2; w++) begin
			apb(1'b1, `CFG2_CH0_OFS, {31'h0, w[0]});
			f0 = n_ok;
			b0 = n_bad;
			r0 = n_rf;
			stn.send_bits(`FLAG_PATTERN, 8);
			repeat (w ? 5 : 3) stn.send_bits(8'h55, 8);
			stn.send_bits(`FLAG_PATTERN, 8);
			repeat (w ? 6 : 4) stn.send_bits(8'h55, 8);
			stn.send_bits(`FLAG_PATTERN, 8);
			stn.send_bits(8'h3F, 7);
			repeat (3) @(posedge clk_in);
			`CHK(n_bad - b0, 1)
			`CHK(n_ok - f0, 1)
			`CHK(n_rf - r0, 4)
		end
		// Unshared, shared, and nothing queued.
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, `CFG2_CH0_OFS, k[0] ? 32'h80 : 32'h0);
			tx_next_queued_in <= (k < 2);
			f0 = n_txf;
			b0 = n_nx;
			@(posedge clk_in) tx_frame_done_in <= 1'b1;
			@(posedge clk_in) tx_frame_done_in <= 1'b0;
			repeat (6) @(posedge clk_in);
			`CHK(n_txf - f0, (k == 0) ? 2 : 1)
			`CHK(n_nx - b0, (k < 2) ? 1 : 0)
		end
		// The last flag preset the transmit CRC to sixteen ones.
		`CHK(tx_crc_out, 32'h0000_FFFF)
		for (int c = 8'h31; c <= 8'h39; c++)
			tx_byte(8'(c));
		@(posedge clk_in);
		`CHK(tx_crc_out, 32'h0000_6F91)
		// Length 1 and three-bit characters give 24 bit times.
		apb(1'b1, `MASK_OFS, 32'h1);
		apb(1'b0, `STATUS_OFS, 32'h0);
		apb(1'b1, `CFG2_CH0_OFS, 32'h0000_8100);
		char_frame_bits_in <= 4'h3;
		f0 = n_to;
		stn.ticks(1'b1, 23);
		`CHK(n_to - f0, 0)
		stn.ticks(1'b0, 1);
		repeat (2) @(posedge clk_in);
		`CHK(n_to - f0, 1)
		`CHK(irq_out, 1'b1)
		apb(1'b0, `STATUS_OFS, 32'h0);
		`CHK(rdat, 32'h0000_0001)
		stn.ticks(1'b0, 30);
		`CHK(irq_out, 1'b0)
		`CHK(n_to - f0, 1)
		apb(1'b1, `CFG2_CH0_OFS, 32'h0000_0100);
		stn.ticks(1'b1, 30);
		`CHK(n_to - f0, 1)
		give_verdict();
	end
endmodule

// ==== testbench/serial_station.sv ====
// Remote serial station model: HDLC bit stream and async character timing.
`timescale 1ns/1ns
module serial_station (
	// Clock.
	input wire logic clk_in,
	// Line side towards the block.
	output logic rx_bit_valid_out,
	output logic rx_bit_out,
	output logic bit_tick_out,
	output logic char_done_out
);
	// The line starts idle with no strobes.
	initial begin
		rx_bit_valid_out = 1'b0;
		rx_bit_out = 1'b1;
		bit_tick_out = 1'b0;
		char_done_out = 1'b0;
	end

	// Sends n bits LSB first; a released line shows the inverse of the
	// last bit so that a stale value is never mistaken for data.
	task automatic send_bits(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			rx_bit_valid_out <= 1'b1;
			rx_bit_out <= b[i];
		end
		@(posedge clk_in);
		rx_bit_valid_out <= 1'b0;
		rx_bit_out <= ~b[n-1];
	endtask

	// Optionally one received character, then n bit-time ticks.
	task automatic ticks(input logic c, input int n);
		if (c) begin
			@(posedge clk_in) char_done_out <= 1'b1;
			@(posedge clk_in) char_done_out <= 1'b0;
		end
		repeat (n) begin
			@(posedge clk_in) bit_tick_out <= 1'b1;
			@(posedge clk_in) bit_tick_out <= 1'b0;
		end
	endtask
endmodule
